/* File: logic/bsr_pkg.sv */
/*
 Package for the byte-wide static RAM host controller: timing figures,
 derived cycle counts, and the request and pin structs.
 Assumes a 100 MHz single clock.
*/
`default_nettype none
package bsr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;
    // Timing figures, ns except the startup delay in us (fastest grade)
    localparam int unsigned LOC_ACCESS_DELAY_NS = 120;
    localparam int unsigned SEL_ACCESS_DELAY_NS = 60;
    localparam int unsigned GATE_ACCESS_DELAY_NS = 60;
    localparam int unsigned LOC_CHANGE_FLOAT_NS = 10;
    localparam int unsigned WR_STROBE_FLOAT_NS = 30;
    localparam int unsigned LOC_SETUP_NS = 0;
    localparam int unsigned LOC_HOLD_NS = 40;
    localparam int unsigned WR_PULSE_WIDTH_NS = 45;
    localparam int unsigned WR_DATA_SETUP_NS = 10;
    localparam int unsigned WR_DATA_HOLD_NS = 10;
    localparam int unsigned CYCLE_TIME_NS = 120;
    localparam int unsigned STARTUP_DELAY_US = 2000;
    // Least times round up, at least one cycle
    function automatic int unsigned ns2cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns2cyc
    // Read sampling waits for the slowest access path plus one sync margin
    localparam int unsigned READ_WAIT_CYC = ns2cyc(LOC_ACCESS_DELAY_NS) + 1;
    localparam int unsigned GATE_WAIT_CYC = ns2cyc(GATE_ACCESS_DELAY_NS);
    localparam int unsigned LOC_SETUP_CYC = ns2cyc(LOC_SETUP_NS);
    localparam int unsigned WR_PULSE_CYC = ns2cyc(WR_PULSE_WIDTH_NS) > ns2cyc(WR_DATA_SETUP_NS) ?
        ns2cyc(WR_PULSE_WIDTH_NS) : ns2cyc(WR_DATA_SETUP_NS);
    localparam int unsigned LOC_HOLD_CYC = ns2cyc(LOC_HOLD_NS) > ns2cyc(WR_DATA_HOLD_NS) ?
        ns2cyc(LOC_HOLD_NS) : ns2cyc(WR_DATA_HOLD_NS);
    localparam int unsigned FLOAT_CYC = ns2cyc(WR_STROBE_FLOAT_NS);
    localparam int unsigned STARTUP_CYC = STARTUP_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 18;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bsr_req_t;

    typedef struct packed {
        logic select_n;
        logic drive_gate_n;
        logic write_strobe_n;
        logic [ADDR_W-1:0] location_select_lines;
    } bsr_ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b011,
        ST_HOLD = 3'b010,
        ST_READ = 3'b110,
        ST_FLOAT = 3'b111,
        ST_START = 3'b101
    } bsr_state_t;
endpackage : bsr_pkg
`default_nettype wire

/* File: logic/bsr_timer.sv */
/*
 Down-counting delay timer: load a count, done pulses as it expires.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bsr_timer #(
    parameter int unsigned W = 18
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic done_o
);
    logic [W-1:0] cnt_q;
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_q <= '0;
        else if (load_i)
            cnt_q <= count_i;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end
    assign done_o = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule : bsr_timer
`default_nettype wire

/* File: logic/bsr_host.sv */
/*
 Host controller for a byte-wide asynchronous static RAM: takes read and
 write requests and sequences the RAM strobes, address and data pins.
 Assumes the RAM pins are wired directly and its data input is sampled
 synchronously to mclk_i; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module bsr_host
    import bsr_pkg::*;
#(
    parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire bsr_pkg::bsr_req_t req_i,
    output logic req_ready_o,
    output logic rdata_valid_o,
    output logic [bsr_pkg::DATA_W-1:0] rdata_o,
    output logic select_n_o,
    output logic drive_gate_n_o,
    output logic write_strobe_n_o,
    output logic [bsr_pkg::ADDR_W-1:0] location_select_lines_o,
    input wire logic [bsr_pkg::DATA_W-1:0] byte_lines_bidir_i,
    output logic [bsr_pkg::DATA_W-1:0] byte_lines_bidir_o,
    output logic byte_lines_bidir_oe_n_o
);
    import bsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    bsr_state_t state_q;
    bsr_ctl_t ctl_q;
    logic write_q;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic tmr_done;

    bsr_timer #(.W(CNT_W)) u_timer (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Timer loads per state entry
    always_comb
    begin
        tmr_load = 1'b0;
        tmr_count = '0;
        case (state_q)
            ST_START:
            begin
                tmr_load = 1'b0;
            end
            ST_IDLE:
            begin
                if (req_valid_i && req_ready_o)
                begin
                    tmr_load = 1'b1;
                    tmr_count = req_i.write ? CNT_W'(LOC_SETUP_CYC) : CNT_W'(READ_WAIT_CYC);
                end
            end
            ST_SETUP:
            begin
                if (tmr_done)
                begin
                    tmr_load = 1'b1;
                    tmr_count = CNT_W'(WR_PULSE_CYC);
                end
            end
            ST_STROBE:
            begin
                if (tmr_done)
                begin
                    tmr_load = 1'b1;
                    tmr_count = CNT_W'(LOC_HOLD_CYC);
                end
            end
            ST_HOLD, ST_READ:
            begin
                if (tmr_done)
                begin
                    tmr_load = 1'b1;
                    tmr_count = CNT_W'(FLOAT_CYC);
                end
            end
            default:
            begin
                tmr_load = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Startup counter: a separate count so the timer is free afterwards
    logic [CNT_W-1:0] boot_q;
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            boot_q <= '0;
        else if (state_q == ST_START && boot_q != CNT_W'(STARTUP_CYCLES))
            boot_q <= boot_q + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_q <= ST_START;
        else
        begin
            case (state_q)
                ST_START:
                    if (boot_q == CNT_W'(STARTUP_CYCLES))
                        state_q <= ST_IDLE;
                ST_IDLE:
                    if (req_valid_i && req_ready_o)
                        state_q <= req_i.write ? ST_SETUP : ST_READ;
                ST_SETUP:
                    if (tmr_done)
                        state_q <= ST_STROBE;
                ST_STROBE:
                    if (tmr_done)
                        state_q <= ST_HOLD;
                ST_HOLD, ST_READ:
                    if (tmr_done)
                        state_q <= ST_FLOAT;
                ST_FLOAT:
                    if (tmr_done)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM control pins
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctl_q <= '{select_n: 1'b1, drive_gate_n: 1'b1, write_strobe_n: 1'b1, location_select_lines: '0};
            write_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (req_valid_i && req_ready_o)
                    begin
                        ctl_q.location_select_lines <= req_i.addr;
                        ctl_q.select_n <= 1'b0;
                        ctl_q.drive_gate_n <= req_i.write;
                        write_q <= req_i.write;
                    end
                ST_SETUP:
                    if (tmr_done)
                        ctl_q.write_strobe_n <= 1'b0;
                ST_STROBE:
                    if (tmr_done)
                        ctl_q.write_strobe_n <= 1'b1;
                ST_HOLD, ST_READ:
                    if (tmr_done)
                    begin
                        ctl_q.select_n <= 1'b1;
                        ctl_q.drive_gate_n <= 1'b1;
                    end
                default:
                    ctl_q.write_strobe_n <= 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data lines: host drives only from setup to end of hold
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            byte_lines_bidir_o <= '0;
            byte_lines_bidir_oe_n_o <= 1'b1;
        end
        else if (state_q == ST_IDLE && req_valid_i && req_ready_o && req_i.write)
        begin
            byte_lines_bidir_o <= req_i.wdata;
            byte_lines_bidir_oe_n_o <= 1'b0;
        end
        else if (state_q == ST_HOLD && tmr_done)
            byte_lines_bidir_oe_n_o <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture and handshake
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_o <= '0;
            rdata_valid_o <= 1'b0;
            req_ready_o <= 1'b0;
        end
        else
        begin
            rdata_valid_o <= 1'b0;
            if (state_q == ST_READ && tmr_done && !write_q)
            begin
                rdata_o <= byte_lines_bidir_i;
                rdata_valid_o <= 1'b1;
            end
            req_ready_o <= (state_q == ST_FLOAT && tmr_done) ||
                (state_q == ST_START && boot_q == CNT_W'(STARTUP_CYCLES)) ||
                (state_q == ST_IDLE && !(req_valid_i && req_ready_o));
        end
    end

    assign select_n_o = ctl_q.select_n;
    assign drive_gate_n_o = ctl_q.drive_gate_n;
    assign write_strobe_n_o = ctl_q.write_strobe_n;
    assign location_select_lines_o = ctl_q.location_select_lines;
endmodule : bsr_host
`default_nettype wire

/* File: dv/bsr_host_monitor.sv */
/* Pin sequencing checker for bsr_host.
 Assumes a bind onto bsr_host and its single clock. */
`timescale 1ns/1ps
`default_nettype none
module bsr_host_monitor
    import bsr_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire bsr_pkg::bsr_req_t req_i,
    input wire logic req_ready_o,
    input wire logic rdata_valid_o,
    input wire logic [bsr_pkg::DATA_W-1:0] rdata_o,
    input wire logic select_n_o,
    input wire logic drive_gate_n_o,
    input wire logic write_strobe_n_o,
    input wire logic [bsr_pkg::ADDR_W-1:0] location_select_lines_o,
    input wire logic [bsr_pkg::DATA_W-1:0] byte_lines_bidir_i,
    input wire logic [bsr_pkg::DATA_W-1:0] byte_lines_bidir_o,
    input wire logic byte_lines_bidir_oe_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////
    property p_wr_sel; !write_strobe_n_o |-> !select_n_o; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("strobe low while deselected");
    property p_wr_gate; !write_strobe_n_o |-> drive_gate_n_o; endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("drive gate open in write");
    property p_wr_drv; !write_strobe_n_o |-> !byte_lines_bidir_oe_n_o; endproperty
    a_wr_drv: assert property (p_wr_drv) else $error("write data not driven");
    property p_hold; $rose(write_strobe_n_o) |-> !byte_lines_bidir_oe_n_o && !select_n_o; endproperty
    a_hold: assert property (p_hold) else $error("data released at strobe rise");
    property p_addr; !write_strobe_n_o && $past(!write_strobe_n_o) |-> $stable(location_select_lines_o); endproperty
    a_addr: assert property (p_addr) else $error("location moved in write pulse");
    property p_end; $rose(select_n_o) |-> write_strobe_n_o && $past(write_strobe_n_o); endproperty
    a_end: assert property (p_end) else $error("write ended by select");
    property p_bus; !byte_lines_bidir_oe_n_o |-> drive_gate_n_o; endproperty
    a_bus: assert property (p_bus) else $error("bus contention");
    property p_rd; req_valid_i && req_ready_o && !req_i.write |-> ##[12:14] rdata_valid_o; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_pulse; $fell(write_strobe_n_o) |-> !write_strobe_n_o [*5] ##1 write_strobe_n_o; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse width wrong");
    property p_idle; req_ready_o |-> select_n_o && write_strobe_n_o; endproperty
    a_idle: assert property (p_idle) else $error("not deselected when idle");
    c_rd: cover property (rdata_valid_o);
    c_wr: cover property ($rose(write_strobe_n_o));
    c_sel: cover property ($rose(select_n_o));
endmodule : bsr_host_monitor
bind bsr_host bsr_host_monitor i_bsr_host_monitor (.*);
`default_nettype wire

/* File: dv/bsr_sram_model.sv */
/* Behavioural 1K x 8 static RAM on the host's pins.
 Assumes the bench resolves the shared data wire. */
`timescale 1ns/1ps
`default_nettype none
module bsr_sram_model
    import bsr_pkg::*;
(
    input wire logic clk_i,
    input wire logic select_n_i,
    input wire logic drive_gate_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [bsr_pkg::ADDR_W-1:0] loc_i,
    input wire logic [bsr_pkg::DATA_W-1:0] data_i,
    output logic [bsr_pkg::DATA_W-1:0] data_o
);
    logic [DATA_W-1:0] mem [1024];
    logic [ADDR_W-1:0] loc_late;
    logic [ADDR_W-1:0] wr_loc;
    logic sel_late;
    logic gate_late;
    realtime t_data;
    ////////////////////////////////////////////////////////////////
    // A hair under nominal, so the sampling edge does not race
    assign #119 loc_late = loc_i;
    assign #59 sel_late = select_n_i;
    assign #59 gate_late = drive_gate_n_i;
    always_comb
    begin
        if (!select_n_i && !drive_gate_n_i && write_strobe_n_i && !sel_late && !gate_late && loc_late == loc_i)
            data_o = mem[loc_i];
        else
            data_o = clk_i ? 8'h69 : 8'h96;
    end
    always @(data_i) t_data = $realtime;
    always @(negedge write_strobe_n_i or negedge select_n_i)
        if (!write_strobe_n_i && !select_n_i)
            wr_loc = loc_i;
    always @(posedge write_strobe_n_i)
    begin
        if (!select_n_i)
            mem[wr_loc] = ($realtime - t_data >= 10.0) ? data_i : ~data_i;
        #10;
        if ($realtime - t_data < 10.0)
            mem[wr_loc] = ~mem[wr_loc];
    end
endmodule : bsr_sram_model
`default_nettype wire

/* File: dv/test_byte_wide_static_ram_port.sv */
/* Self-checking bench for bsr_host against a RAM model.
 Assumes a shortened startup count. */
`timescale 1ns/1ps
`default_nettype none
module test_byte_wide_static_ram_port;
    import bsr_pkg::*;
    localparam int unsigned START_CYC = 20;
    typedef struct packed {logic write; logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] data;} bsr_row_t;
    localparam bsr_row_t ROWS [10] = '{
        '{1'b1, 10'h000, 8'ha5}, '{1'b1, 10'h3ff, 8'h5a}, '{1'b1, 10'h155, 8'hc3}, '{1'b1, 10'h2aa, 8'h00},
        '{1'b0, 10'h000, 8'ha5}, '{1'b0, 10'h3ff, 8'h5a}, '{1'b0, 10'h155, 8'hc3}, '{1'b0, 10'h2aa, 8'h00},
        '{1'b1, 10'h155, 8'hff}, '{1'b0, 10'h155, 8'hff}};
    logic mclk_i;
    logic resetn_i;
    logic req_valid_i;
    bsr_req_t req_i;
    logic req_ready_o;
    logic rdata_valid_o;
    logic [DATA_W-1:0] rdata_o;
    logic select_n_o;
    logic drive_gate_n_o;
    logic write_strobe_n_o;
    logic [ADDR_W-1:0] loc;
    logic [DATA_W-1:0] ram_dq;
    logic [DATA_W-1:0] host_dq;
    logic host_oe_n;
    logic [DATA_W-1:0] wire_dq;
    int bad_count = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////////
    // Released wire toggles 3c/c3 with the clock, not a held copy of the last byte
    assign wire_dq = host_oe_n ? (mclk_i ? 8'h3c : 8'hc3) : host_dq;
    always #5 mclk_i = ~mclk_i;
    bsr_host #(.STARTUP_CYCLES(START_CYC)) i_bsr_host (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o),
        .rdata_o(rdata_o), .select_n_o(select_n_o), .drive_gate_n_o(drive_gate_n_o),
        .write_strobe_n_o(write_strobe_n_o), .location_select_lines_o(loc), .byte_lines_bidir_i(ram_dq),
        .byte_lines_bidir_o(host_dq), .byte_lines_bidir_oe_n_o(host_oe_n));
    bsr_sram_model i_bsr_sram_model (.clk_i(mclk_i), .select_n_i(select_n_o), .drive_gate_n_i(drive_gate_n_o),
        .write_strobe_n_i(write_strobe_n_o), .loc_i(loc), .data_i(wire_dq), .data_o(ram_dq));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic wait_ready;
        int n;
        n = 0;
        // Falling edge only, so a registered output is looked at once it has settled
        while (req_ready_o !== 1'b1 && n < 40)
        begin
            @(negedge mclk_i);
            n++;
        end
        check(req_ready_o, 1);
    endtask : wait_ready
    task automatic access(input bsr_row_t r);
        int n;
        @(negedge mclk_i);
        req_valid_i = 1'b1;
        req_i = r;
        // Request held until ready is seen, then taken on the next rising edge
        wait_ready();
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        n = 0;
        while (!r.write && rdata_valid_o !== 1'b1 && n < 30)
        begin
            @(negedge mclk_i);
            n++;
        end
        if (!r.write)
            check(rdata_o, r.data);
        wait_ready();
    endtask : access
    task automatic startup;
        req_valid_i = 1'b1;
        req_i = '{1'b1, 10'h155, 8'h11};
        repeat (START_CYC - 2)
        begin
            @(negedge mclk_i);
            check({req_ready_o, write_strobe_n_o}, 2'b01);
        end
        req_valid_i = 1'b0;
        wait_ready();
    endtask : startup
    initial
    begin
        // Whole run is a few microseconds; this leaves ample slack
        #20us;
        bad_count++;
        end_sim();
    end
    initial
    begin
        mclk_i = 1'b0;
        resetn_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        repeat (8) @(negedge mclk_i);
        resetn_i = 1'b1;
        startup();
        foreach (ROWS[i])
            access(ROWS[i]);
        @(negedge mclk_i);
        resetn_i = 1'b0;
        @(negedge mclk_i);
        check({select_n_o, drive_gate_n_o, write_strobe_n_o, host_oe_n, req_ready_o}, 5'b11110);
        resetn_i = 1'b1;
        startup();
        access('{1'b0, 10'h155, 8'hff});
        end_sim();
    end
endmodule : test_byte_wide_static_ram_port
`default_nettype wire
